// ==== csm_defines.vh ====
// Constants of the converter shutdown mask block.
// Assumes one 100 MHz system clock and a 32-bit classic Wishbone slave port.
`ifndef CSM_DEFINES_VH
`define CSM_DEFINES_VH

// Converter count, one of 8, 16 or 32
`define CSM_NUM_CONV     32
// Control inputs that may be masked
`define CSM_NUM_CTL      6
// Width of the converter index field
`define CSM_IDX_W        6
// Width of an off delay value
`define CSM_DLY_W        16
// Converter counts above this use the slow delay unit
`define CSM_SMALL_MAX    16

// Clock period and off delay units
`define CSM_CLK_PERIOD_NS 10
`define CSM_LSB_SMALL_US  250
`define CSM_LSB_LARGE_US  500
`define CSM_NS_PER_US     1000

// Register byte offsets
`define CSM_ADR_W        8
`define CSM_ADR_INDEX    8'h00
`define CSM_ADR_CTL_MASK 8'h04
`define CSM_ADR_PG_MASK  8'h08
`define CSM_ADR_OFF_DLY  8'h0c
`define CSM_ADR_ON_REQ   8'h10
`define CSM_ADR_EN_STAT  8'h14
`define CSM_ADR_IRQ_STAT 8'h18
`define CSM_ADR_IRQ_MASK 8'h1c

// Reset values
`define CSM_RST_INDEX    6'h01
`define CSM_RST_ZERO     32'h0000_0000

`endif

// ==== csm_shutdown_mask.v ====
// Converter shutdown mask logic: per-converter masks, off delay, enables.
// Assumes ctl_i and pgood_i are asynchronous pins and the host uses Wishbone.
//
// The Wishbone slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "csm_defines.vh"

module csm_shutdown_mask #(
   parameter [15:0] OFF_TICK_CYC = ((`CSM_NUM_CONV <= `CSM_SMALL_MAX) ?
                                    `CSM_LSB_SMALL_US : `CSM_LSB_LARGE_US)
                                   * `CSM_NS_PER_US / `CSM_CLK_PERIOD_NS
) (
   input  wire                      clk_sys_i,
   input  wire                      sys_rst_i,
   input  wire                      wb_cyc_i,
   input  wire                      wb_stb_i,
   input  wire                      wb_we_i,
   input  wire [`CSM_ADR_W-1:0]     wb_adr_i,
   input  wire [3:0]                wb_sel_i,
   input  wire [31:0]               wb_dat_i,
   output wire [31:0]               wb_dat_o,
   output wire                      wb_ack_o,
   input  wire [`CSM_NUM_CTL-1:0]   ctl_i,
   input  wire [`CSM_NUM_CONV-1:0]  pgood_i,
   output wire [`CSM_NUM_CONV-1:0]  en_o,
   output wire                      irq_o
);

   localparam N  = `CSM_NUM_CONV;
   localparam NC = `CSM_NUM_CTL;
   localparam DW = `CSM_DLY_W;
   localparam [`CSM_IDX_W-1:0] N_IDX = `CSM_NUM_CONV;
   // Converter states
   localparam [1:0] ST_OFF  = 2'b00;
   localparam [1:0] ST_ON   = 2'b01;
   localparam [1:0] ST_STOP = 2'b10;

   // Bus side state
   reg  [`CSM_IDX_W-1:0] conv_idx_r;
   reg  [N-1:0]          on_req_r;
   reg  [N-1:0]          irq_stat_r;
   reg  [N-1:0]          irq_mask_r;
   reg                   wb_ack_r;
   reg  [31:0]           wb_dat_r;
   reg                   irq_r;

   // Per-converter configuration
   reg  [NC-1:0]         ctl_mask_r [0:N-1];
   reg  [N-1:0]          pg_mask_r  [0:N-1];
   reg  [DW-1:0]         off_dly_r  [0:N-1];

   // Input synchronisers and edge history
   reg  [NC-1:0]         ctl_meta_r;
   reg  [NC-1:0]         ctl_sync_r;
   reg  [NC-1:0]         ctl_prev_r;
   reg  [N-1:0]          pg_meta_r;
   reg  [N-1:0]          pg_sync_r;
   reg  [N-1:0]          pg_prev_r;

   // Off delay time base
   reg  [15:0]           div_cnt_r;
   reg                   tick_r;

   wire [NC-1:0]         ctl_fall;
   wire [N-1:0]          pg_fall;
   wire [N-1:0]          trip_evt;
   wire [N-1:0]          en_w;
   wire                  idx_ok;
   wire [4:0]            idx0;
   wire [N-1:0]          own_bit;
   wire                  bus_req;
   wire                  bus_acc;
   wire                  bus_wr;
   reg  [31:0]           rd_nxt;
   reg  [N-1:0]          irq_stat_nxt;
   reg  [N-1:0]          pg_wr_nxt;
   reg  [31:0]           dly_wr_nxt;
   integer               i;
   // Byte-lane merge of a write into an old value
   function [31:0] lane_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  sel;
      integer      b;
      begin
         lane_merge = old_v;
         for (b = 0; b < 4; b = b + 1) begin
            if (sel[b]) begin
               lane_merge[b*8 +: 8] = new_v[b*8 +: 8];
            end
         end
      end
   endfunction

   assign wb_dat_o = wb_dat_r;
   assign wb_ack_o = wb_ack_r;
   assign en_o     = en_w;
   assign irq_o    = irq_r;

   assign idx_ok  = (conv_idx_r != {`CSM_IDX_W{1'b0}}) &&
                    (conv_idx_r <= N_IDX);
   assign idx0    = conv_idx_r[4:0] - 5'h01;
   assign own_bit = {{(N-1){1'b0}}, 1'b1} << idx0;

   // Request seen, and the edge where the master takes the answer
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign bus_acc = bus_req & wb_ack_r;
   assign bus_wr  = bus_acc & wb_we_i;

   // Two-stage synchronisers, then one stage of history
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         ctl_meta_r <= {NC{1'b1}};
         ctl_sync_r <= {NC{1'b1}};
         ctl_prev_r <= {NC{1'b1}};
         pg_meta_r  <= {N{1'b0}};
         pg_sync_r  <= {N{1'b0}};
         pg_prev_r  <= {N{1'b0}};
      end else begin
         ctl_meta_r <= ctl_i;
         ctl_sync_r <= ctl_meta_r;
         ctl_prev_r <= ctl_sync_r;
         pg_meta_r  <= pgood_i;
         pg_sync_r  <= pg_meta_r;
         pg_prev_r  <= pg_sync_r;
      end
   end

   // De-assertion edges
   assign ctl_fall = ctl_prev_r & ~ctl_sync_r;
   assign pg_fall  = pg_prev_r & ~pg_sync_r;

   // Delay unit divider, one-cycle tick
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         div_cnt_r <= 16'h0000;
         tick_r    <= 1'b0;
      end else if (div_cnt_r == OFF_TICK_CYC - 16'h0001) begin
         div_cnt_r <= 16'h0000;
         tick_r    <= 1'b1;
      end else begin
         div_cnt_r <= div_cnt_r + 16'h0001;
         tick_r    <= 1'b0;
      end
   end

   // Write values of the power-good mask and of the off delay
   // The power-good value has the converter's own bit dropped
   always @* begin
      dly_wr_nxt = lane_merge({16'h0000, off_dly_r[idx0]}, wb_dat_i, wb_sel_i);
      pg_wr_nxt = lane_merge(pg_mask_r[idx0], wb_dat_i, wb_sel_i);
      pg_wr_nxt = pg_wr_nxt & ~own_bit;
   end

   // Register writes
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         conv_idx_r <= `CSM_RST_INDEX;
         on_req_r   <= `CSM_RST_ZERO;
         irq_mask_r <= `CSM_RST_ZERO;
         for (i = 0; i < N; i = i + 1) begin
            ctl_mask_r[i] <= {NC{1'b0}};
            pg_mask_r[i]  <= `CSM_RST_ZERO;
            off_dly_r[i]  <= {DW{1'b0}};
         end
      end else begin
         if (bus_wr) begin
            case (wb_adr_i)
               `CSM_ADR_INDEX: begin
                  if (wb_sel_i[0]) begin
                     conv_idx_r <= wb_dat_i[`CSM_IDX_W-1:0];
                  end
               end
               `CSM_ADR_CTL_MASK: begin
                  if (idx_ok && wb_sel_i[0]) begin
                     ctl_mask_r[idx0] <= wb_dat_i[NC-1:0];
                  end
               end
               `CSM_ADR_PG_MASK: begin
                  if (idx_ok) begin
                     pg_mask_r[idx0] <= pg_wr_nxt;
                  end
               end
               `CSM_ADR_OFF_DLY: begin
                  if (idx_ok) begin
                     off_dly_r[idx0] <= dly_wr_nxt[DW-1:0];
                  end
               end
               `CSM_ADR_IRQ_MASK: begin
                  irq_mask_r <= lane_merge(irq_mask_r, wb_dat_i, wb_sel_i);
               end
               // On request bits are written below, together with the fault clear
               default: conv_idx_r <= conv_idx_r;
            endcase
         end
         // A shutdown by fault withdraws the power-on request
         on_req_r <= (bus_wr && wb_adr_i == `CSM_ADR_ON_REQ) ?
                     lane_merge(on_req_r, wb_dat_i, wb_sel_i) & ~trip_evt :
                     on_req_r & ~trip_evt;
      end
   end

   // Read data for the current address
   always @* begin
      rd_nxt = `CSM_RST_ZERO;
      case (wb_adr_i)
         `CSM_ADR_INDEX: rd_nxt[`CSM_IDX_W-1:0] = conv_idx_r;
         `CSM_ADR_CTL_MASK: begin
            if (idx_ok) begin
               rd_nxt[NC-1:0] = ctl_mask_r[idx0];
            end
         end
         `CSM_ADR_PG_MASK: begin
            if (idx_ok) begin
               rd_nxt[N-1:0] = pg_mask_r[idx0] & ~own_bit;
            end
         end
         `CSM_ADR_OFF_DLY: begin
            if (idx_ok) begin
               rd_nxt[DW-1:0] = off_dly_r[idx0];
            end
         end
         `CSM_ADR_ON_REQ:   rd_nxt[N-1:0] = on_req_r;
         `CSM_ADR_EN_STAT:  rd_nxt[N-1:0] = en_w;
         `CSM_ADR_IRQ_STAT: rd_nxt[N-1:0] = irq_stat_r;
         `CSM_ADR_IRQ_MASK: rd_nxt[N-1:0] = irq_mask_r;
         default:           rd_nxt = `CSM_RST_ZERO;
      endcase
   end

   // Classic Wishbone answer one cycle after the request
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         wb_ack_r <= 1'b0;
         wb_dat_r <= `CSM_RST_ZERO;
      end else begin
         wb_ack_r <= bus_req & ~wb_ack_r;
         if (bus_req & ~wb_ack_r & ~wb_we_i) begin
            wb_dat_r <= rd_nxt;
         end
      end
   end

   // Sticky status, read clears, new event wins
   always @* begin
      irq_stat_nxt = irq_stat_r;
      if (bus_acc && !wb_we_i && wb_adr_i == `CSM_ADR_IRQ_STAT) begin
         irq_stat_nxt = {N{1'b0}};
      end
      irq_stat_nxt = irq_stat_nxt | trip_evt;
   end

   // Status and interrupt output
   always @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         irq_stat_r <= `CSM_RST_ZERO;
         irq_r      <= 1'b0;
      end else begin
         irq_stat_r <= irq_stat_nxt;
         irq_r      <= |(irq_stat_nxt & irq_mask_r);
      end
   end

   // Per-converter shutdown decision and off delay
   genvar g;
   generate
      for (g = 0; g < N; g = g + 1) begin : g_conv
         reg  [1:0]    st_r;
         reg  [DW:0]   cnt_r;
         reg           en_r;
         wire          trip;
         wire          dly_done;
         assign trip = (|(ctl_fall & ctl_mask_r[g])) |
                       (|(pg_fall & pg_mask_r[g])) | pg_fall[g];
         assign trip_evt[g] = (st_r == ST_ON) & trip;
         // at least the full off delay
         assign dly_done = (off_dly_r[g] == {DW{1'b0}}) ||
                           (cnt_r == {1'b0, off_dly_r[g]} + {{DW{1'b0}}, 1'b1});
         assign en_w[g] = en_r;
         always @(posedge clk_sys_i) begin
            if (sys_rst_i) begin
               st_r  <= ST_OFF;
               cnt_r <= {(DW+1){1'b0}};
               en_r  <= 1'b0;
            end else begin
               case (st_r)
                  ST_OFF: begin
                     cnt_r <= {(DW+1){1'b0}};
                     if (on_req_r[g]) begin
                        st_r <= ST_ON;
                        en_r <= 1'b1;
                     end
                  end
                  ST_ON: begin
                     if (trip || !on_req_r[g]) begin
                        st_r <= ST_STOP;
                     end
                  end
                  ST_STOP: begin
                     if (dly_done) begin
                        st_r  <= ST_OFF;
                        en_r  <= 1'b0;
                        cnt_r <= {(DW+1){1'b0}};
                     end else if (tick_r) begin
                        cnt_r <= cnt_r + {{DW{1'b0}}, 1'b1};
                     end
                  end
                  default: begin
                     st_r <= ST_OFF;
                     en_r <= 1'b0;
                  end
               endcase
            end
         end
      end
   endgenerate

endmodule

// ==== csm_conv_model.sv ====
// Behavioural model of the converters behind the enable outputs.
// Assumes one clock; the bench may force a rail's power-good low.
`timescale 1ns/1ps
`include "csm_defines.vh"
module csm_conv_model (
   input  wire logic [`CSM_NUM_CONV-1:0] en_i,
   input  wire logic                     clk_sys_i,
   input  wire logic [`CSM_NUM_CONV-1:0] fail_i,
   input  wire logic                     slow_i,
   output logic      [`CSM_NUM_CONV-1:0] pgood_o
);
   logic [`CSM_NUM_CONV-1:0] ramp_r [0:7];
   // Power-good low until the first edges settle the ramp
   initial pgood_o = 32'h0000_0000;
   // Rail ramps up after enable, quickly or slowly; off or failed reads low
   always @(posedge clk_sys_i) begin
      ramp_r[0] <= en_i;
      for (int i = 1; i < 8; i++)
         ramp_r[i] <= ramp_r[i-1] & en_i;
      pgood_o <= (slow_i ? ramp_r[7] : ramp_r[1]) & en_i & ~fail_i;
   end
endmodule

// ==== csm_shutdown_mask_asserts.sv ====
// Checker of the shutdown mask block, bound to its top module.
// Assumes converter 1 masks are written with all byte lanes on.
`timescale 1ns/1ps
`include "csm_defines.vh"
module csm_shutdown_mask_asserts #(
   parameter [15:0] OFF_TICK_CYC = 16'h0004
) (
   input wire logic                     clk_sys_i,
   input wire logic                     sys_rst_i,
   input wire logic                     wb_cyc_i,
   input wire logic                     wb_stb_i,
   input wire logic                     wb_we_i,
   input wire logic [`CSM_ADR_W-1:0]    wb_adr_i,
   input wire logic [3:0]               wb_sel_i,
   input wire logic [31:0]              wb_dat_i,
   input wire logic [31:0]              wb_dat_o,
   input wire logic                     wb_ack_o,
   input wire logic [`CSM_NUM_CTL-1:0]  ctl_i,
   input wire logic [`CSM_NUM_CONV-1:0] pgood_i,
   input wire logic [`CSM_NUM_CONV-1:0] en_o,
   input wire logic                     irq_o
);
   logic [5:0]  idx_r, ctm_r, ctl_r;
   logic [31:0] pgm_r, pg_r;
   wire         acc = wb_ack_o & wb_cyc_i & wb_stb_i;
   wire         rd_c = acc & !wb_we_i & (wb_adr_i == `CSM_ADR_CTL_MASK);
   wire         rd_p = acc & !wb_we_i & (wb_adr_i == `CSM_ADR_PG_MASK);
   wire         wr1 = acc & wb_we_i & (idx_r == 6'h01);
   // Shadow of the index, of converter 1 masks and of last input levels
   always_ff @(posedge clk_sys_i) begin
      ctl_r <= ctl_i;
      pg_r <= pgood_i;
      if (sys_rst_i) begin
         idx_r <= `CSM_RST_INDEX;
         ctm_r <= 6'h00;
         pgm_r <= 32'h0000_0000;
      end else begin
         if (acc && wb_we_i && wb_adr_i == `CSM_ADR_INDEX && wb_sel_i[0])
            idx_r <= wb_dat_i[5:0];
         if (wr1 && wb_adr_i == `CSM_ADR_CTL_MASK)
            ctm_r <= wb_dat_i[5:0];
         if (wr1 && wb_adr_i == `CSM_ADR_PG_MASK)
            pgm_r <= wb_dat_i;
      end
   end
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);
   // Converter 1 enable drops within the allowed span
   sequence s_drop;
      ##[3:60] !en_o[0];
   endsequence
   a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ctl_readback: assert property (rd_c && idx_r == 6'h01 |-> wb_dat_o == {26'h0, ctm_r})
      else $error("control mask read back wrong");
   a_index_range: assert property ((rd_c || rd_p) && (idx_r == 6'h00 || idx_r > 6'h20)
      |-> wb_dat_o == 32'h0)
      else $error("bad index read not zero");
   a_own_hidden: assert property (rd_p && idx_r != 6'h00 && idx_r <= 6'h20
      |-> !wb_dat_o[idx_r - 6'h01])
      else $error("own power-good bit reported");
   a_own_fault: assert property (en_o[0] && $fell(pgood_i[0]) |-> s_drop)
      else $error("own power-good loss ignored");
   a_pg_fault: assert property (en_o[0] && |(pg_r & ~pgood_i & pgm_r) |-> s_drop)
      else $error("masked power-good loss ignored");
   a_ctl_fault: assert property (en_o[0] && |(ctl_r & ~ctl_i & ctm_r) |-> s_drop)
      else $error("masked control loss ignored");
endmodule
bind csm_shutdown_mask csm_shutdown_mask_asserts #(.OFF_TICK_CYC(OFF_TICK_CYC)) u_chk (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctl_i(ctl_i), .pgood_i(pgood_i),
   .en_o(en_o), .irq_o(irq_o));

// ==== csm_shutdown_mask_test.sv ====
// Bench of the shutdown mask block: bus tasks and directed tests.
// Assumes the converter model raises power-good some cycles after enable.
`timescale 1ns/1ps
`include "csm_defines.vh"
module csm_shutdown_mask_test;
   localparam logic [15:0] TICK = 16'h0004;
   logic        clk_sys_i = 1'b0, sys_rst_i = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, slow = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'h0;
   logic [5:0]  ctl = 6'h3f;
   logic [31:0] wdat = 32'h0, rdat, got, pgood, en, fail = 32'h0;
   logic [5:0]  idx [4] = '{6'h01, 6'h02, 6'h11, 6'h20};
   int          bad_count = 0, tests_run = 0, n;
   csm_shutdown_mask #(.OFF_TICK_CYC(TICK)) u_csm_shutdown_mask (
      .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .ctl_i(ctl), .pgood_i(pgood), .en_o(en), .irq_o(irq));
   csm_conv_model u_csm_conv_model (.clk_sys_i(clk_sys_i), .en_i(en), .fail_i(fail),
      .slow_i(slow), .pgood_o(pgood));
   // System clock
   initial forever #5 clk_sys_i = ~clk_sys_i;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One classic cycle, held until ack is sampled high
   task automatic wb_io(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, 4'hf, d};
      // Only the watchdog ends a wait for ack
      do begin
         @(posedge clk_sys_i);
      end while (ack !== 1'b1);
      got = rdat;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      wb_io(1'b0, a, 32'h0);
      chk(got, e);
   endtask
   task automatic set_conv(input logic [5:0] i, c, input logic [31:0] p, input logic [15:0] d);
      wb_io(1'b1, `CSM_ADR_INDEX, {26'h0, i});
      wb_io(1'b1, `CSM_ADR_CTL_MASK, {26'h0, c});
      wb_io(1'b1, `CSM_ADR_PG_MASK, p);
      wb_io(1'b1, `CSM_ADR_OFF_DLY, {16'h0, d});
   endtask
   task automatic wait_en(input logic [31:0] e);
      int k;
      k = 0;
      while (en !== e && k < 200) begin
         @(posedge clk_sys_i);
         k++;
      end
      chk(en, e);
   endtask
   task automatic wrap_up;
      $display("%0d checks, %0d wrong", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Watchdog, far beyond the few hundred cycles the tests need
   initial begin
      #100us;
      bad_count++;
      wrap_up();
   end
   // Directed tests
   initial begin
      repeat (6) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      rd_chk(`CSM_ADR_INDEX, 32'h1);
      wb_io(1'b1, 8'h40, 32'hffff_ffff);
      rd_chk(8'h40, 32'h0);
      $display("reset and decode test done");
      foreach (idx[i]) set_conv(idx[i], idx[i], 32'hffff_ffff, 16'h0);
      foreach (idx[i]) begin
         wb_io(1'b1, `CSM_ADR_INDEX, {26'h0, idx[i]});
         rd_chk(`CSM_ADR_CTL_MASK, {26'h0, idx[i]});
         rd_chk(`CSM_ADR_PG_MASK, ~(32'h1 << (idx[i] - 6'h01)));
      end
      wb_io(1'b1, `CSM_ADR_INDEX, 32'h21);
      rd_chk(`CSM_ADR_PG_MASK, 32'h0);
      $display("mask store test done");
      set_conv(6'h01, 6'h00, 32'h0, 16'h2);
      wb_io(1'b1, `CSM_ADR_IRQ_MASK, 32'h1);
      wb_io(1'b1, `CSM_ADR_ON_REQ, 32'h1);
      wait_en(32'h1);
      repeat (12) @(posedge clk_sys_i);
      fail[0] <= 1'b1;
      n = 0;
      while (en[0] === 1'b1 && n < 100) begin
         @(posedge clk_sys_i);
         n++;
      end
      chk({31'h0, n >= 2 * TICK && n <= 3 * TICK + 8}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      rd_chk(`CSM_ADR_IRQ_STAT, 32'h1);
      rd_chk(`CSM_ADR_ON_REQ, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("own fault test done");
      fail[0] <= 1'b0;
      slow <= 1'b1;
      set_conv(6'h01, 6'h08, 32'h4, 16'h0);
      set_conv(6'h02, 6'h00, 32'h0, 16'h0);
      set_conv(6'h03, 6'h00, 32'h0, 16'h0);
      wb_io(1'b1, `CSM_ADR_ON_REQ, 32'h7);
      wait_en(32'h7);
      repeat (16) @(posedge clk_sys_i);
      ctl[3] <= 1'b0;
      wait_en(32'h6);
      repeat (20) @(posedge clk_sys_i);
      chk(en, 32'h6);
      rd_chk(`CSM_ADR_IRQ_STAT, 32'h1);
      ctl[3] <= 1'b1;
      wb_io(1'b1, `CSM_ADR_IRQ_MASK, 32'h0);
      wb_io(1'b1, `CSM_ADR_ON_REQ, 32'h7);
      wait_en(32'h7);
      repeat (16) @(posedge clk_sys_i);
      fail[2] <= 1'b1;
      wait_en(32'h2);
      chk({31'h0, irq}, 32'h0);
      wb_io(1'b1, `CSM_ADR_IRQ_MASK, 32'h4);
      wb_io(1'b1, `CSM_ADR_EN_STAT, 32'h0);
      chk({31'h0, irq}, 32'h1);
      rd_chk(`CSM_ADR_EN_STAT, 32'h2);
      rd_chk(`CSM_ADR_IRQ_STAT, 32'h5);
      fail[2] <= 1'b0;
      wb_io(1'b1, `CSM_ADR_ON_REQ, 32'h0);
      wait_en(32'h0);
      ctl[3] <= 1'b0;
      repeat (10) @(posedge clk_sys_i);
      rd_chk(`CSM_ADR_IRQ_STAT, 32'h0);
      chk({31'h0, irq}, 32'h0);
      $display("masked fault test done");
      wrap_up();
   end
endmodule
